// [rtl/smbpec_pkg.sv]
/*
  Shared constants and types for the SMBus target with packet error checking.
  Assumes the strap pads arrive already encoded as two-bit levels.
*/
package smbpec_pkg;

  // four-level strap encoding as delivered by the pad comparators
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_RES  = 2'h1;
  localparam logic [1:0] STRAP_FLT  = 2'h2;
  localparam logic [1:0] STRAP_HIGH = 2'h3;

  // address group bases chosen by the high strap
  localparam logic [6:0] GRP_LOW  = 7'h10;
  localparam logic [6:0] GRP_RES  = 7'h40;
  localparam logic [6:0] GRP_FLT  = 7'h44;
  localparam logic [6:0] GRP_HIGH = 7'h50;

  // crc-8, x^8+x^2+x+1, zero start
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // bit counter marks
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;

  // received byte positions (address is position 0)
  localparam logic [2:0] POS_CMD = 3'h1;
  localparam logic [2:0] POS_D0  = 3'h2;
  localparam logic [2:0] POS_D1  = 3'h3;
  localparam logic [2:0] POS_MAX = 3'h7;
  localparam logic [2:0] HDR_LEN = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACKT, ST_TX, ST_ACKR, ST_WAIT
  } smbpec_state_e;

  // state on the link clock
  typedef struct packed {
    logic bit_v;
  } smbpec_link_s;

  // one executed write
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] data;
    logic [1:0]  len;
  } smbpec_wr_s;

  // state on the main clock
  typedef struct packed {
    logic [1:0]    sda_sy;
    logic          sda_q;
    logic [1:0]    scl_sy;
    logic          scl_q;
    logic [3:0]    strap_s1;
    logic [3:0]    strap_s2;
    smbpec_state_e st;
    logic [3:0]    bitcnt;
    logic [7:0]    sh;
    logic [2:0]    nrx;
    logic          addr_ph;
    logic [7:0]    cmd;
    logic [7:0]    d0;
    logic [7:0]    d1;
    logic [7:0]    crc;
    logic          rd;
    logic          nocmd;
    logic          last;
    logic          pec_sent;
    logic          hack;
    logic          rd_act;
    logic [5:0]    idx;
    logic          sda_o;
    logic          sda_oe_n;
    logic          wr_valid;
    smbpec_wr_s    wr;
    logic          pec_err;
  } smbpec_core_s;

endpackage

// [rtl/smbpec_target.sv]
/*
  SMBus target byte engine with optional packet error check per message.
  Assumes a user block on mclk that decodes command codes: it gives the
  write length of the latched command and the byte to send at rd_idx,
  combinationally. smb_clk is the bus clock pin, used as a clock.
*/
`timescale 1ns/10ps
`default_nettype none
module smbpec_target (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                smb_clk,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_n,
  input  wire logic [1:0]          addr_strap_low_pin,
  input  wire logic [1:0]          addr_strap_high_pin,
  input  wire logic [1:0]          cmd_wr_len,
  input  wire logic [7:0]          rd_byte,
  input  wire logic                rd_last,
  output logic [7:0]               cmd_code,
  output logic [5:0]               rd_idx,
  output logic                     rd_active,
  output logic                     rd_nocmd,
  output smbpec_pkg::smbpec_wr_s   wr_cmd,
  output logic                     wr_valid,
  output logic                     pec_err,
  input  wire logic                pec_err_clr
);

  smbpec_pkg::smbpec_link_s lk_r;
  smbpec_pkg::smbpec_link_s lk_nxt;
  smbpec_pkg::smbpec_core_s r;
  smbpec_pkg::smbpec_core_s n;

  // one crc-8 step over a whole byte
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ smbpec_pkg::CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  // group base from the high strap level
  function automatic logic [6:0] grp(input logic [1:0] s);
    logic [6:0] b;
    unique case (s)
      smbpec_pkg::STRAP_LOW: b = smbpec_pkg::GRP_LOW;
      smbpec_pkg::STRAP_RES: b = smbpec_pkg::GRP_RES;
      smbpec_pkg::STRAP_FLT: b = smbpec_pkg::GRP_FLT;
      smbpec_pkg::STRAP_HIGH: b = smbpec_pkg::GRP_HIGH;
    endcase
    return b;
  endfunction

  // link side: sample data on each rising bus clock.
  // no reset here: the bus clock may stand still during reset, and the
  // main side reads bit_v only after it has seen a clock rise itself.
  // a toggle handshake would need a reset that this domain cannot get,
  // so the qualifier is the bus clock level synchronised on mclk.
  always_comb begin
    lk_nxt.bit_v = sda_i;
  end

  always_ff @(posedge smb_clk) begin
    lk_r <= lk_nxt;
  end

  logic       start_ev;
  logic       stop_ev;
  logic       rise_ev;
  logic       fall_ev;
  logic [6:0] my_addr;
  logic [7:0] byte_in;
  logic [7:0] txb;
  logic       keep;
  logic       load;

  // events seen on the main clock
  always_comb begin
    start_ev = r.scl_sy[1] & r.scl_q & r.sda_q & ~r.sda_sy[1];
    stop_ev  = r.scl_sy[1] & r.scl_q & ~r.sda_q & r.sda_sy[1];
    rise_ev  = r.scl_sy[1] & ~r.scl_q; // bit_v has settled by now and holds a whole bit
    fall_ev  = r.scl_q & ~r.scl_sy[1];
    my_addr  = grp(r.strap_s2[3:2]) | {5'h00, r.strap_s2[1:0]};
    byte_in  = {r.sh[6:0], lk_r.bit_v};
  end

  // protocol engine
  always_comb begin
    n          = r;
    txb        = rd_byte;
    load       = 1'b0;
    keep       = 1'b0;
    n.wr_valid = 1'b0;
    n.sda_o    = 1'b0;
    // synchronisers: the first stage feeds only the second
    n.sda_sy   = {r.sda_sy[0], sda_i};
    n.sda_q    = r.sda_sy[1];
    n.scl_sy   = {r.scl_sy[0], smb_clk};
    n.scl_q    = r.scl_sy[1];
    // the synchronised clock rise qualifies lk_r.bit_v, which holds until the next rise
    n.strap_s1 = {addr_strap_high_pin, addr_strap_low_pin};
    n.strap_s2 = r.strap_s1;

    if (start_ev) begin
      // a start after address-write and command is the read turnaround;
      // the start's own clock rise has already been counted as one bit
      keep = (r.st == smbpec_pkg::ST_RX) & ~r.rd & ~r.addr_ph
           & (r.nrx == smbpec_pkg::POS_D0) & (r.bitcnt <= 4'h1);
      n.st       = smbpec_pkg::ST_RX;
      n.bitcnt   = 4'h0;
      n.addr_ph  = 1'b1;
      n.sda_oe_n = 1'b1;
      n.rd       = 1'b0;
      if (!keep) begin
        n.crc = smbpec_pkg::CRC_INIT;
        n.nrx = 3'h0;
      end
    end else if (stop_ev) begin
      // only a write ending on a byte boundary may execute
      // the stop's own clock rise counts as a bit, so a boundary reads 0 or 1
      if (r.st == smbpec_pkg::ST_RX && r.bitcnt <= 4'h1 && !r.rd && !r.addr_ph
          && r.nrx >= smbpec_pkg::POS_D0) begin
        if (r.nrx == smbpec_pkg::HDR_LEN + {1'b0, cmd_wr_len}) begin
          n.wr_valid = 1'b1;
        end else if (r.nrx == smbpec_pkg::HDR_LEN + {1'b0, cmd_wr_len} + 3'h1) begin
          // crc over the message and its check byte is zero when intact
          if (r.crc == smbpec_pkg::CRC_INIT) begin
            n.wr_valid = 1'b1;
          end else begin
            n.pec_err = 1'b1;
          end
        end
      end
      // the payload moves only with an executed write, so it stands until the next one
      if (n.wr_valid) begin
        n.wr.cmd  = r.cmd;
        n.wr.data = {r.d1, r.d0};
        n.wr.len  = cmd_wr_len;
      end
      n.st       = smbpec_pkg::ST_IDLE;
      n.sda_oe_n = 1'b1;
    end else begin
      unique case (r.st)
        smbpec_pkg::ST_IDLE, smbpec_pkg::ST_WAIT: begin
          n.sda_oe_n = 1'b1;
        end
        smbpec_pkg::ST_RX: begin
          if (rise_ev) begin
            n.sh     = byte_in;
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == smbpec_pkg::BIT_LAST) begin
              n.bitcnt = 4'h0;
              n.crc    = crc8(r.crc, byte_in);
              if (r.nrx != smbpec_pkg::POS_MAX) begin
                n.nrx = r.nrx + 3'h1;
              end
              if (r.addr_ph) begin
                if (byte_in[7:1] == my_addr) begin
                  n.addr_ph = 1'b0;
                  n.rd      = byte_in[0];
                  n.nocmd   = (r.nrx == 3'h0);
                  n.idx     = 6'h00;
                  n.st      = smbpec_pkg::ST_ACKT;
                end else begin
                  n.st = smbpec_pkg::ST_WAIT; // not ours, stay off the bus
                end
              end else begin
                if (r.nrx == smbpec_pkg::POS_CMD) begin
                  n.cmd = byte_in;
                end
                if (r.nrx == smbpec_pkg::POS_D0) begin
                  n.d0 = byte_in;
                end
                if (r.nrx == smbpec_pkg::POS_D1) begin
                  n.d1 = byte_in;
                end
                n.st = smbpec_pkg::ST_ACKT;
              end
            end
          end
        end
        smbpec_pkg::ST_ACKT: begin
          // pull low from the eighth falling edge to the ninth
          if (fall_ev && r.sda_oe_n) begin
            n.sda_oe_n = 1'b0;
          end else if (fall_ev) begin
            n.sda_oe_n = 1'b1;
            n.st       = smbpec_pkg::ST_RX;
            if (r.rd) begin
              txb        = rd_byte;
              n.last     = rd_last;
              n.pec_sent = 1'b0;
              load       = 1'b1;
            end
          end
        end
        smbpec_pkg::ST_TX: begin
          if (rise_ev) begin
            n.bitcnt = r.bitcnt + 4'h1;
          end
          if (fall_ev) begin
            if (r.bitcnt == smbpec_pkg::BIT_DONE) begin
              // release for the host acknowledge; fetch the next index early
              n.sda_oe_n = 1'b1;
              n.bitcnt   = 4'h0;
              n.idx      = r.idx + 6'h01;
              n.st       = smbpec_pkg::ST_ACKR;
            end else begin
              n.sda_oe_n = r.sh[6];
              n.sh       = {r.sh[6:0], 1'b0};
            end
          end
        end
        smbpec_pkg::ST_ACKR: begin
          if (rise_ev) begin
            n.hack = lk_r.bit_v;
          end
          if (fall_ev) begin
            // a high acknowledge or a sent check byte ends our part
            if (r.hack || r.pec_sent) begin
              n.st = smbpec_pkg::ST_WAIT;
            end else if (r.last) begin
              txb        = r.crc;
              n.pec_sent = 1'b1;
              load       = 1'b1;
            end else begin
              txb    = rd_byte;
              n.last = rd_last;
              load   = 1'b1;
            end
          end
        end
        default: begin
          n.st = smbpec_pkg::ST_IDLE;
        end
      endcase
    end

    // start a byte out: first bit goes on the wire at once
    if (load) begin
      n.sh       = txb;
      n.sda_oe_n = txb[7];
      n.crc      = crc8(r.crc, txb);
      n.bitcnt   = 4'h0;
      n.hack     = 1'b0;
      n.st       = smbpec_pkg::ST_TX;
    end

    // read phase flag, registered so the output comes straight from a flop
    n.rd_act = n.rd & ((n.st == smbpec_pkg::ST_TX) | (n.st == smbpec_pkg::ST_ACKR));

    // error flag: a new error in the clearing cycle wins only while the flag is clear
    if (pec_err_clr && !(n.pec_err && !r.pec_err)) begin
      n.pec_err = 1'b0;
    end

    if (!rst_n) begin
      n          = '0;
      n.st       = smbpec_pkg::ST_IDLE;
      n.sda_oe_n = 1'b1;
      // pins idle high: starting the synchronisers there avoids false edges
      n.sda_sy   = 2'h3;
      n.sda_q    = 1'b1;
      n.scl_sy   = 2'h3;
      n.scl_q    = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    r <= n;
  end

  // outputs straight from the state register
  assign sda_o     = r.sda_o;
  assign sda_oe_n  = r.sda_oe_n;
  assign cmd_code  = r.cmd;
  assign rd_idx    = r.idx;
  assign rd_active = r.rd_act;
  assign rd_nocmd  = r.nocmd;
  assign wr_cmd    = r.wr;
  assign wr_valid  = r.wr_valid;
  assign pec_err   = r.pec_err;

endmodule
`default_nettype wire

// [tb/smbpec_target_asserts.sv]
/*
  port checker for the smbus target.
  assumes the host leaves the bus idle for some cycles after each stop.
*/
`timescale 1ns/10ps
`default_nettype none
module smbpec_target_asserts (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   smb_clk,
  input wire logic                   sda_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_n,
  input wire logic [7:0]             cmd_code,
  input wire smbpec_pkg::smbpec_wr_s wr_cmd,
  input wire logic                   wr_valid,
  input wire logic                   pec_err,
  input wire logic                   pec_err_clr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // the pin only ever pulls low, and a pull only starts while the bus clock is low
  chk_pull_zero: assert property (sda_o == 1'b0) else $error("pin drives high");
  chk_ack_scl_low: assert property ($fell(sda_oe_n) |-> !smb_clk) else $error("pull with clock high");
  chk_reset_quiet: assert property ($rose(rst_n) |-> sda_oe_n && !wr_valid && !pec_err)
    else $error("not quiet after reset");
  // writes execute as one pulse after a stop, with a steady payload
  chk_wr_pulse: assert property (wr_valid |=> !wr_valid) else $error("write pulse too long");
  chk_wr_hold: assert property (!wr_valid ##1 !wr_valid |-> $stable(wr_cmd)) else $error("payload moved");
  chk_wr_cmd_match: assert property (wr_valid |-> wr_cmd.cmd == cmd_code) else $error("command differs");
  chk_wr_after_stop: assert property (wr_valid |-> smb_clk && sda_i && sda_oe_n)
    else $error("write before stop");
  // the error flag is sticky, cleared only on request, exclusive with execution
  chk_err_sticky: assert property (pec_err && !pec_err_clr |=> pec_err) else $error("flag lost");
  chk_err_clear: assert property ($fell(pec_err) |-> $past(pec_err_clr)) else $error("flag cleared");
  chk_err_no_exec: assert property ($rose(pec_err) |-> !wr_valid) else $error("bad write executed");
  cover property (wr_valid);
  cover property ($rose(pec_err));
  cover property ($fell(sda_oe_n) ##1 !smb_clk);
endmodule
bind smbpec_target smbpec_target_asserts u_chk (.mclk, .rst_n, .smb_clk, .sda_i, .sda_o, .sda_oe_n,
  .cmd_code, .wr_cmd, .wr_valid, .pec_err, .pec_err_clr);
`default_nettype wire

// [tb/smbpec_host.sv]
/*
  bus host model: drives the bus clock and its data pull.
  assumes the bench forms the wired-and line and a 12 ns tick clock.
*/
`timescale 1ns/10ps
`default_nettype none
module smbpec_host (
  input  wire logic lclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_h
);
  localparam int HALF = 40; // ticks per half bit, keeps the bus far below mclk
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // data moves mid low phase, away from the clock edges
  task automatic bitx(input logic b, output logic r);
    tick(HALF / 2);
    sda_h <= b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    tick(HALF / 2);
    sda_h <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_h <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
  endtask
  // clock stands high after the stop
  task automatic stop();
    tick(HALF / 2);
    sda_h <= 1'b0;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_h <= 1'b1;
    tick(HALF);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(nack, r);
  endtask
endmodule
`default_nettype wire

// [tb/smbpec_target_tb_top.sv]
/*
  bench for the smbus target: host model on a 12 ns tick, user decoder below.
  assumes a pull-up on the data line.
*/
`timescale 1ns/10ps
`default_nettype none
module smbpec_target_tb_top;
  logic                   mclk, rst_n, lclk, smb_clk, sda_h, sda_o, sda_oe_n, a, rd_last;
  logic                   rd_active, rd_nocmd, wr_valid, pec_err, pec_err_clr;
  logic [1:0]             addr_strap_low_pin, addr_strap_high_pin, cmd_wr_len;
  logic [7:0]             cmd_code, rd_byte, crc, d;
  logic [5:0]             rd_idx;
  logic [6:0]             addr;
  smbpec_pkg::smbpec_wr_s wr_cmd, got;
  int                     n_mismatch = 0, checked = 0, n_wr = 0, cyc = 0, n;
  wire logic              sda_i = sda_h & (sda_oe_n | sda_o); // open drain, pull-up
  // user decoder: command code gives write byte count 0..2
  assign cmd_wr_len = (cmd_code[1:0] == 2'h3) ? 2'h0 : cmd_code[1:0];
  assign rd_byte = 8'ha0 + {2'h0, rd_idx};
  assign rd_last = rd_idx == {4'h0, cmd_code[1:0]} - 6'h01;
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #6 lclk = ~lclk;
  end
  smbpec_target DUT (.mclk, .rst_n, .smb_clk, .sda_i, .sda_o, .sda_oe_n, .addr_strap_low_pin,
    .addr_strap_high_pin, .cmd_wr_len, .rd_byte, .rd_last, .cmd_code, .rd_idx, .rd_active,
    .rd_nocmd, .wr_cmd, .wr_valid, .pec_err, .pec_err_clr);
  smbpec_host host (.lclk, .sda(sda_i), .scl(smb_clk), .sda_h);
  // executed writes and the hang limit, a little over twice the expected run;
  // sampled on the falling edge, away from the edge that launches the pulse
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (wr_valid) begin
      n_wr <= n_wr + 1;
      got <= wr_cmd;
    end
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction
  task automatic put(input logic [7:0] b);
    host.wbyte(b, a);
    crc = crc8(crc, b);
    chk(a, 1'b0);
  endtask
  // pec: 0 none, 1 correct, 2 corrupted
  task automatic wmsg(input logic [7:0] q[$], input int pec);
    host.start();
    crc = 8'h00;
    put({addr, 1'b0});
    foreach (q[i]) put(q[i]);
    if (pec != 0) put(crc ^ ((pec == 2) ? 8'h01 : 8'h00));
    host.stop();
  endtask
  // command 8'hff means receive byte, with no command phase
  task automatic rmsg(input logic [7:0] c, input int n, input logic pec);
    host.start();
    crc = 8'h00;
    if (c != 8'hff) begin
      put({addr, 1'b0});
      put(c);
      host.start();
    end
    put({addr, 1'b1});
    chk(rd_nocmd, c == 8'hff);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1 && !pec, d);
      crc = crc8(crc, d);
      chk(d, 8'ha0 + i);
      if (i == 0) chk(rd_active, 1'b1);
    end
    if (pec) begin
      host.rbyte(1'b1, d);
      chk(d, crc);
    end
    host.stop();
    chk(rd_active, 1'b0);
  endtask
  task automatic t_addr();
    logic [6:0] grp [4];
    grp = '{7'h10, 7'h40, 7'h44, 7'h50};
    for (int h = 0; h < 4; h++)
      for (int l = 0; l < 4; l++) begin
        @(negedge mclk);
        addr_strap_high_pin = h[1:0];
        addr_strap_low_pin = l[1:0];
        addr = grp[h] + 7'(l);
        repeat (4) @(negedge mclk);
        host.start();
        host.wbyte({addr ^ 7'h20, 1'b0}, a);
        chk(a, 1'b1);
        host.stop();
        n = n_wr;
        wmsg({8'h00}, 0);
        chk(n_wr, n + 1);
      end
  endtask
  task automatic t_write();
    n = n_wr;
    wmsg({8'h02, 8'h34, 8'h12}, 0);
    chk(got, {8'h02, 16'h1234, 2'h2});
    wmsg({8'h01, 8'h5a}, 1);
    chk({got.cmd, got.data[7:0]}, 16'h015a);
    wmsg({8'h02, 8'h78, 8'h56}, 2);
    chk(n_wr, n + 2);
    chk(pec_err, 1'b1);
    @(negedge mclk);
    pec_err_clr = 1'b1;
    @(negedge mclk);
    pec_err_clr = 1'b0;
    @(negedge mclk);
    chk(pec_err, 1'b0);
  endtask
  // a reset in mid-run drops a pending error flag and leaves the pin released
  task automatic t_reset();
    wmsg({8'h01, 8'h22}, 2);
    chk(pec_err, 1'b1);
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk(pec_err, 1'b0);
    chk(sda_oe_n, 1'b1);
    repeat (3) @(negedge mclk);
  endtask
  // group command: another target first, then our part with its check byte
  task automatic t_group();
    host.start();
    host.wbyte({addr ^ 7'h20, 1'b0}, a);
    host.wbyte(8'h01, a);
    wmsg({8'h01, 8'h66}, 1);
    chk({got.cmd, got.data[7:0]}, 16'h0166);
  endtask
  // a start inside a half-sent byte must not lock the target
  task automatic t_partial();
    host.start();
    put({addr, 1'b0});
    for (int i = 0; i < 4; i++) host.bitx(1'b0, a);
    wmsg({8'h01, 8'h3c}, 1);
    chk({got.cmd, got.data[7:0]}, 16'h013c);
  endtask
  initial begin
    rst_n = 1'b0;
    pec_err_clr = 1'b0;
    addr_strap_low_pin = 2'h0;
    addr_strap_high_pin = 2'h0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_addr();
    t_write();
    t_reset();
    t_group();
    t_partial();
    rmsg(8'h02, 2, 1'b1);
    rmsg(8'h03, 3, 1'b1);
    rmsg(8'h01, 1, 1'b0);
    rmsg(8'h01, 1, 1'b1);
    rmsg(8'h01, 1, 1'b1);
    rmsg(8'hff, 1, 1'b1);
    results();
  end
endmodule
`default_nettype wire
